//--- pms_params.svh
`ifndef PMS_PARAMS_SVH
`define PMS_PARAMS_SVH

// apb byte addresses
`define PMS_ADDR_CMD        8'h00
`define PMS_ADDR_STATUS     8'h04
`define PMS_ADDR_REGSEL     8'h08
`define PMS_ADDR_RDATA      8'h0C
`define PMS_ADDR_WDATA      8'h10
`define PMS_ADDR_SIREV      8'h18

// internal phy register indexes
`define PMS_PHY_CTRL1       5'h00
`define PMS_PHY_STAT_LATCH  5'h01
`define PMS_PHY_ID_HIGH     5'h02
`define PMS_PHY_ID_LOW      5'h03
`define PMS_PHY_STAT_LIVE   5'h11
`define PMS_PHY_LED_CFG     5'h14

// mgmt_command / mgmt_status bits
`define PMS_CMD_READ_BIT    0
`define PMS_CMD_SCAN_BIT    1
`define PMS_ST_BUSY_BIT     0
`define PMS_ST_SCAN_BIT     1
`define PMS_ST_INVALID_BIT  2

// phy_status_latched bits
`define PMS_L_FDPX_BIT      12
`define PMS_L_HDPX_BIT      11
`define PMS_L_LINK_BIT      2
`define PMS_L_JABBER_BIT    1

// phy_status_live bits
`define PMS_V_TX_BIT        13
`define PMS_V_RX_BIT        12
`define PMS_V_COL_BIT       11
`define PMS_V_LINK_BIT      10
`define PMS_V_DPX_BIT       9
`define PMS_V_POL_BIT       5

// phy_control_one duplex bit
`define PMS_C_DPX_BIT       8

// led config: reset value and mask of reserved bits
`define PMS_LED_RESET       16'h3422
`define PMS_LED_RSVD_MASK   16'hF001

// identity values, arbitrary
`define PMS_OUI_BITS        22'h0A5A5A
`define PMS_PART_NUM        6'h15
`define PMS_PHY_REV         4'h3
`define PMS_SILICON_REV     5'h07

// management access time in sys_clk cycles
`define PMS_MGMT_CYCLES     4'h8

`endif

//--- pms_pkg.sv
package pms_pkg;

    // management engine states, one-hot
    typedef enum logic [2:0] {
        PMS_IDLE  = 3'b001,
        PMS_READ  = 3'b010,
        PMS_WRITE = 3'b100
    } pms_state_t;

    // live indications from the embedded phy
    typedef struct packed {
        logic transmitting;
        logic receiving;
        logic collision;
        logic link_up;
        logic jabber;
        logic pol_reversed;
    } pms_phy_in_t;

    // apb request from the master
    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pms_apb_req_t;

endpackage

//--- pms_mgmt_status.sv
`include "pms_params.svh"

module pms_mgmt_status (
    input wire logic sys_clk,
    input wire logic rst,
    input wire pms_pkg::pms_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pms_pkg::pms_phy_in_t phy_in,
    input wire logic second_led_pin
);

    localparam int MGMT_LAT = `PMS_MGMT_CYCLES;
    localparam logic [21:0] OUI_BITS = `PMS_OUI_BITS;

    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    logic strap_s1_r, strap_s2_r;
    logic cmd_read_r;
    logic cmd_scan_r;
    logic [4:0] reg_sel_r;
    logic [15:0] read_data_r;
    logic [15:0] write_data_r;
    logic wr_pend_r;
    logic invalid_r;
    logic busy_r;
    logic scan_run_r;
    logic op_single_r;
    logic [4:0] op_reg_r;
    logic [3:0] cnt_r;
    pms_pkg::pms_state_t state_r;
    logic duplex_r;
    logic [15:0] led_cfg_r;
    logic link_latch_r, jabber_r;
    logic access, wr_fire, mapped, op_done, start_read, start_write;
    logic [15:0] phy_word;
    logic [15:0] stat_latch_word, stat_live_word;
    logic [31:0] rd_mux;

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // address decode for the error answer; the read mux decodes with its own case
    function automatic logic addr_ok(input logic [7:0] a);
        case (a)
            `PMS_ADDR_CMD, `PMS_ADDR_STATUS, `PMS_ADDR_REGSEL,
            `PMS_ADDR_RDATA, `PMS_ADDR_WDATA, `PMS_ADDR_SIREV: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction

    // access phase of apb; write lands only on the ready edge
    assign access = apb_req.psel && apb_req.penable;
    assign wr_fire = access && pready_r && apb_req.pwrite && !pslverr_r;
    assign mapped = addr_ok(apb_req.paddr);

    // strap pin crosses in from outside, two stages before use
    always_ff @(posedge sys_clk)
    begin
        strap_s1_r <= second_led_pin;
        strap_s2_r <= strap_s1_r;
    end

    // one wait state: ready and data are registered one cycle into access
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else if (access && !pready_r)
        begin
            pready_r <= 1'b1;
            pslverr_r <= !mapped;
            prdata_r <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
        end
        else
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // register read mux; unimplemented bits are zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (apb_req.paddr)
            `PMS_ADDR_CMD:
            begin
                rd_mux[`PMS_CMD_READ_BIT] = cmd_read_r;
                rd_mux[`PMS_CMD_SCAN_BIT] = cmd_scan_r;
            end
            `PMS_ADDR_STATUS:
            begin
                rd_mux[`PMS_ST_BUSY_BIT] = busy_r;
                rd_mux[`PMS_ST_SCAN_BIT] = scan_run_r;
                rd_mux[`PMS_ST_INVALID_BIT] = invalid_r;
            end
            `PMS_ADDR_REGSEL: rd_mux[4:0] = reg_sel_r;
            `PMS_ADDR_RDATA: rd_mux[15:0] = read_data_r;
            `PMS_ADDR_WDATA: rd_mux[15:0] = write_data_r;
            `PMS_ADDR_SIREV: rd_mux[4:0] = `PMS_SILICON_REV;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // software control registers; only implemented bits are stored
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cmd_scan_r <= 1'b0;
            reg_sel_r <= 5'h00;
            write_data_r <= 16'h0000;
        end
        else if (wr_fire)
        begin
            case (apb_req.paddr)
                `PMS_ADDR_CMD: cmd_scan_r <= apb_req.pwdata[`PMS_CMD_SCAN_BIT];
                `PMS_ADDR_REGSEL: reg_sel_r <= apb_req.pwdata[4:0];
                `PMS_ADDR_WDATA: write_data_r <= apb_req.pwdata[15:0];
                default: cmd_scan_r <= cmd_scan_r;
            endcase
        end
    end

    // single read request; hardware clear on completion, set wins
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            cmd_read_r <= 1'b0;
        else if (wr_fire && apb_req.paddr == `PMS_ADDR_CMD)
            cmd_read_r <= apb_req.pwdata[`PMS_CMD_READ_BIT];
        else if (op_done && op_single_r)
            cmd_read_r <= 1'b0;
    end

    // a write to the data register queues one phy write
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            wr_pend_r <= 1'b0;
        else if (wr_fire && apb_req.paddr == `PMS_ADDR_WDATA)
            wr_pend_r <= 1'b1;
        else if (start_write)
            wr_pend_r <= 1'b0;
    end

    // engine start: write first, then single read, then scan
    assign start_write = (state_r == pms_pkg::PMS_IDLE) && wr_pend_r;
    assign start_read = (state_r == pms_pkg::PMS_IDLE) && !wr_pend_r
        && (cmd_read_r || cmd_scan_r);
    assign op_done = (state_r != pms_pkg::PMS_IDLE) && (cnt_r == 4'h1);

    // management engine: every access takes a fixed number of cycles
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_r <= pms_pkg::PMS_IDLE;
            cnt_r <= 4'h0;
            op_reg_r <= 5'h00;
            op_single_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                pms_pkg::PMS_IDLE:
                begin
                    if (start_write || start_read)
                    begin
                        state_r <= start_write ? pms_pkg::PMS_WRITE : pms_pkg::PMS_READ;
                        cnt_r <= `PMS_MGMT_CYCLES;
                        op_reg_r <= reg_sel_r;
                        op_single_r <= start_read && cmd_read_r;
                    end
                end
                pms_pkg::PMS_READ, pms_pkg::PMS_WRITE:
                begin
                    cnt_r <= cnt_r - 4'h1;
                    if (op_done)
                        state_r <= pms_pkg::PMS_IDLE;
                end
                default: state_r <= pms_pkg::PMS_IDLE;
            endcase
        end
    end

    // busy mirrors the engine so it clears with the completing edge
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            busy_r <= 1'b0;
        else if (start_write || start_read)
            busy_r <= 1'b1;
        else if (op_done)
            busy_r <= 1'b0;
    end

    // scan in progress from first scan read until scan is disabled and idle
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            scan_run_r <= 1'b0;
        else if (start_read && !cmd_read_r)
            scan_run_r <= 1'b1;
        else if (!cmd_scan_r && state_r == pms_pkg::PMS_IDLE)
            scan_run_r <= 1'b0;
    end

    // invalid rises when a read starts and falls when read data is loaded
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            invalid_r <= 1'b0;
        else if (start_read)
            invalid_r <= 1'b1;
        else if (op_done && state_r == pms_pkg::PMS_READ)
            invalid_r <= 1'b0;
    end

    // read data captured at the end of every read, scan or single
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            read_data_r <= 16'h0000;
        else if (op_done && state_r == pms_pkg::PMS_READ)
            read_data_r <= phy_word;
    end

    // phy status words built from live inputs, latches and the duplex control bit
    always_comb
    begin
        stat_latch_word = 16'h0000;
        stat_latch_word[`PMS_L_FDPX_BIT] = 1'b1;
        stat_latch_word[`PMS_L_HDPX_BIT] = 1'b1;
        stat_latch_word[`PMS_L_LINK_BIT] = link_latch_r;
        stat_latch_word[`PMS_L_JABBER_BIT] = jabber_r;
        stat_live_word = 16'h0000;
        stat_live_word[`PMS_V_TX_BIT] = phy_in.transmitting;
        stat_live_word[`PMS_V_RX_BIT] = phy_in.receiving;
        stat_live_word[`PMS_V_COL_BIT] = phy_in.collision;
        stat_live_word[`PMS_V_LINK_BIT] = phy_in.link_up;
        stat_live_word[`PMS_V_DPX_BIT] = duplex_r;
        stat_live_word[`PMS_V_POL_BIT] = phy_in.pol_reversed;
    end

    // internal phy register space seen by the management engine
    always_comb
    begin
        phy_word = 16'h0000;
        case (op_reg_r)
            `PMS_PHY_CTRL1: phy_word[`PMS_C_DPX_BIT] = duplex_r;
            `PMS_PHY_STAT_LATCH: phy_word = stat_latch_word;
            `PMS_PHY_ID_HIGH: phy_word = OUI_BITS[21:6];
            `PMS_PHY_ID_LOW: phy_word = {OUI_BITS[5:0], `PMS_PART_NUM, `PMS_PHY_REV};
            `PMS_PHY_STAT_LIVE: phy_word = stat_live_word;
            `PMS_PHY_LED_CFG: phy_word = led_cfg_r;
            default: phy_word = 16'h0000;
        endcase
    end

    // duplex control: reset value from synchronised strap, then phy writes
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            duplex_r <= strap_s2_r;
        else if (op_done && state_r == pms_pkg::PMS_WRITE && op_reg_r == `PMS_PHY_CTRL1)
            duplex_r <= write_data_r[`PMS_C_DPX_BIT];
    end

    // led config: reserved bits are forced so a careless write cannot move them
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            led_cfg_r <= `PMS_LED_RESET;
        else if (op_done && state_r == pms_pkg::PMS_WRITE && op_reg_r == `PMS_PHY_LED_CFG)
            led_cfg_r <= (write_data_r & ~`PMS_LED_RSVD_MASK)
                | (`PMS_LED_RESET & `PMS_LED_RSVD_MASK);
    end

    // latching link: a read of the latched status re-arms from the live link
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            link_latch_r <= 1'b0;
        else if (op_done && state_r == pms_pkg::PMS_READ
            && op_reg_r == `PMS_PHY_STAT_LATCH)
            link_latch_r <= phy_in.link_up;
        else
            link_latch_r <= link_latch_r && phy_in.link_up;
    end

    // latching jabber: a new event beats the clear on read
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            jabber_r <= 1'b0;
        else if (phy_in.jabber)
            jabber_r <= 1'b1;
        else if (op_done && state_r == pms_pkg::PMS_READ
            && op_reg_r == `PMS_PHY_STAT_LATCH)
            jabber_r <= 1'b0;
    end

    property p_read_len;
        @(posedge sys_clk) disable iff (rst)
        start_read |-> ##MGMT_LAT op_done ##1 (state_r == pms_pkg::PMS_IDLE && !invalid_r);
    endproperty
    a_read_len: assert property (p_read_len)
        else $error("read did not complete in the fixed access time");

    property p_single_clear;
        @(posedge sys_clk) disable iff (rst)
        (op_done && op_single_r) |=> (!cmd_read_r && !busy_r && !invalid_r);
    endproperty
    a_single_clear: assert property (p_single_clear)
        else $error("single read completion left a flag set");

    property p_scan_repeat;
        @(posedge sys_clk) disable iff (rst)
        (op_done && cmd_scan_r && !wr_pend_r && !wr_fire)
            |=> ##1 (state_r == pms_pkg::PMS_READ);
    endproperty
    a_scan_repeat: assert property (p_scan_repeat)
        else $error("scan did not start the next read");

    property p_scan_status;
        @(posedge sys_clk) disable iff (rst)
        (state_r == pms_pkg::PMS_READ && !op_single_r) |-> scan_run_r;
    endproperty
    a_scan_status: assert property (p_scan_status)
        else $error("scan read running without scan status");

    property p_busy;
        @(posedge sys_clk) disable iff (rst)
        busy_r == (state_r != pms_pkg::PMS_IDLE);
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy disagrees with engine state");

    property p_link_drop;
        @(posedge sys_clk) disable iff (rst)
        !phy_in.link_up |=> !link_latch_r;
    endproperty
    a_link_drop: assert property (p_link_drop)
        else $error("latched link stayed up after link loss");

    property p_jabber;
        @(posedge sys_clk) disable iff (rst)
        phy_in.jabber |=> jabber_r [*1] ##0 stat_latch_word[`PMS_L_JABBER_BIT];
    endproperty
    a_jabber: assert property (p_jabber)
        else $error("jabber event not latched");

    property p_ready_pulse;
        @(posedge sys_clk) disable iff (rst)
        (access && !pready_r) |=> (pready_r ##1 !pready_r);
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("apb ready not a single cycle after one wait");

    property p_status_zero;
        @(posedge sys_clk) disable iff (rst)
        (access && !pready_r && !apb_req.pwrite && apb_req.paddr == `PMS_ADDR_STATUS)
            |=> (prdata_r[31:3] == 29'h0000_0000);
    endproperty
    a_status_zero: assert property (p_status_zero)
        else $error("unimplemented status bits read nonzero");

endmodule

//--- pms_phy_model.sv
// embedded phy stand-in: registers the levels the bench asks for
module pms_phy_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [4:0] levels,
    input wire logic jab_req,
    output pms_pkg::pms_phy_in_t phy_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // levels order: tx, rx, collision, link, polarity; jabber is a one-cycle event
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            phy_in <= '0;
        end
        else
        begin
            phy_in.transmitting <= levels[4];
            phy_in.receiving <= levels[3];
            phy_in.collision <= levels[2];
            phy_in.link_up <= levels[1];
            phy_in.pol_reversed <= levels[0];
            phy_in.jabber <= jab_req;
        end
    end
endmodule

//--- tb.sv
`include "pms_params.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [21:0] OUI_BITS = `PMS_OUI_BITS;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic second_led_pin = 1'b1;
    logic [4:0] levels = 5'h00;
    logic jab_req = 1'b0;
    pms_pkg::pms_apb_req_t req = '0;
    pms_pkg::pms_phy_in_t phy_in;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic last_err;
    logic [31:0] q;
    int fail_count = 0;
    int checks = 0;

    always #10 sys_clk = ~sys_clk;

    pms_mgmt_status uut (.sys_clk(sys_clk), .rst(rst), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .phy_in(phy_in), .second_led_pin(second_led_pin));

    pms_phy_model phy (.sys_clk(sys_clk), .rst(rst), .levels(levels), .jab_req(jab_req),
        .phy_in(phy_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; the request stands until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge sys_clk);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            chk(32'h0, 32'h1);
        q = prdata;
        last_err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        // one idle edge so no signal is assigned twice in a time step
        @(posedge sys_clk);
    endtask

    // poll status until busy, scan and invalid are all low, bounded
    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, `PMS_ADDR_STATUS, 32'h0);
            n++;
        end
        while (q[2:0] !== 3'h0 && n < 30);
        chk(q, 32'h0);
    endtask

    task automatic phy_read(input logic [4:0] idx, input logic [15:0] exp);
        apb(1'b1, `PMS_ADDR_REGSEL, {27'h0, idx});
        apb(1'b1, `PMS_ADDR_CMD, 32'h1);
        apb(1'b0, `PMS_ADDR_STATUS, 32'h0);
        chk(q, 32'h5);
        wait_idle();
        apb(1'b0, `PMS_ADDR_CMD, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, `PMS_ADDR_RDATA, 32'h0);
        chk(q, {16'h0, exp});
    endtask

    task automatic phy_write(input logic [4:0] idx, input logic [15:0] d);
        apb(1'b1, `PMS_ADDR_REGSEL, {27'h0, idx});
        apb(1'b1, `PMS_ADDR_WDATA, {16'h0, d});
        wait_idle();
    endtask

    // reset values, read-only words, unmapped address
    task automatic t_regs();
        apb(1'b0, `PMS_ADDR_STATUS, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, `PMS_ADDR_SIREV, 32'h0);
        chk(q, 32'h7);
        apb(1'b1, `PMS_ADDR_SIREV, 32'h1F);
        apb(1'b0, `PMS_ADDR_SIREV, 32'h0);
        chk(q, 32'h7);
        apb(1'b1, `PMS_ADDR_CMD, 32'hFFFF_FFFC);
        apb(1'b0, `PMS_ADDR_CMD, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        chk({q[31:1], last_err}, 32'h1);
    endtask

    task automatic t_ident();
        phy_read(`PMS_PHY_ID_HIGH, OUI_BITS[21:6]);
        phy_read(`PMS_PHY_ID_LOW, {OUI_BITS[5:0], `PMS_PART_NUM, `PMS_PHY_REV});
        phy_read(`PMS_PHY_CTRL1, 16'h0100);
    endtask

    // reserved led bits keep their reset value, host writes them back
    task automatic t_led();
        phy_read(`PMS_PHY_LED_CFG, 16'h3422);
        phy_write(`PMS_PHY_LED_CFG, 16'h3FFE);
        phy_read(`PMS_PHY_LED_CFG, 16'h3FFE);
    endtask

    // strap low across a mid-run reset: half duplex, led config back at reset value
    task automatic t_reset();
        phy_write(`PMS_PHY_CTRL1, 16'h0100);
        phy_read(`PMS_PHY_CTRL1, 16'h0100);
        second_led_pin <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        apb(1'b0, `PMS_ADDR_STATUS, 32'h0);
        chk(q, 32'h0);
        phy_read(`PMS_PHY_CTRL1, 16'h0000);
        phy_read(`PMS_PHY_STAT_LIVE, 16'h0000);
        phy_read(`PMS_PHY_LED_CFG, `PMS_LED_RESET);
    endtask

    task automatic t_latched();
        levels <= 5'h02;
        phy_read(`PMS_PHY_STAT_LATCH, 16'h1800);
        phy_read(`PMS_PHY_STAT_LATCH, 16'h1804);
        levels <= 5'h00;
        repeat (3) @(posedge sys_clk);
        levels <= 5'h02;
        phy_read(`PMS_PHY_STAT_LATCH, 16'h1800);
        jab_req <= 1'b1;
        @(posedge sys_clk);
        jab_req <= 1'b0;
        phy_read(`PMS_PHY_STAT_LATCH, 16'h1806);
        phy_read(`PMS_PHY_STAT_LATCH, 16'h1804);
    endtask

    // each live level alone, duplex strap high
    task automatic t_live();
        logic [4:0] v[6] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
        logic [15:0] e[6] = '{16'h0200, 16'h2200, 16'h1200, 16'h0A00, 16'h0600, 16'h0220};
        for (int i = 0; i < 6; i++)
        begin
            levels <= v[i];
            phy_read(`PMS_PHY_STAT_LIVE, e[i]);
        end
    endtask

    task automatic t_scan();
        levels <= 5'h00;
        apb(1'b1, `PMS_ADDR_REGSEL, {27'h0, `PMS_PHY_STAT_LIVE});
        apb(1'b1, `PMS_ADDR_CMD, 32'h2);
        apb(1'b0, `PMS_ADDR_STATUS, 32'h0);
        chk({29'h0, q[2:0]}, 32'h7);
        levels <= 5'h10;
        repeat (40) @(posedge sys_clk);
        apb(1'b0, `PMS_ADDR_RDATA, 32'h0);
        chk(q, 32'h2200);
        apb(1'b1, `PMS_ADDR_CMD, 32'h0);
        wait_idle();
        apb(1'b0, `PMS_ADDR_STATUS, 32'h0);
        chk(q, 32'h0);
    endtask

    // clearing the duplex control bit shows in the live register
    task automatic t_duplex();
        levels <= 5'h00;
        phy_write(`PMS_PHY_CTRL1, 16'h0000);
        phy_read(`PMS_PHY_STAT_LIVE, 16'h0000);
    endtask

    task automatic final_report();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_regs();
        t_ident();
        t_led();
        t_latched();
        t_live();
        t_scan();
        t_duplex();
        t_reset();
        final_report();
    end

    // hang guard: the whole sequence takes under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        final_report();
    end
endmodule
